// [shared/motor_prot_pkg.sv]
// Constants, register map, fault layout and state codes of the motor protection monitor.
// Assumes a single 25 MHz clock and a 0.1 s protection tick derived from it.
package motor_prot_pkg;

	// Clock and protection tick
	localparam int CLK_HZ = 25_000_000;
	localparam int TICK_MS = 100;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int DIV_W = 22;
	localparam int HOUR_S = 3600;
	localparam logic [15:0] HOUR_TICKS = 16'(HOUR_S * 1000 / TICK_MS);

	// Register port
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam logic [3:0] A_JAM_LVL = 4'h0;
	localparam logic [3:0] A_JAM_DLY = 4'h1;
	localparam logic [3:0] A_STALL_DLY = 4'h2;
	localparam logic [3:0] A_CTRL = 4'h3;
	localparam logic [3:0] A_GF_LVL = 4'h4;
	localparam logic [3:0] A_GF_DLY = 4'h5;
	localparam logic [3:0] A_GF_INH = 4'h6;
	localparam logic [3:0] A_GFA_LVL = 4'h7;
	localparam logic [3:0] A_GFA_DLY = 4'h8;
	localparam logic [3:0] A_STARTS_PH = 4'h9;
	localparam logic [3:0] A_RST_ATT = 4'ha;
	localparam logic [3:0] A_RST_DLY = 4'hb;
	localparam logic [3:0] A_STATUS = 4'hc;
	localparam logic [3:0] A_FAULT_CLR = 4'hd;
	localparam logic [3:0] A_START_CNT = 4'he;

	// Control word bits
	localparam int C_GF_EN = 0;
	localparam int C_GFA_EN = 1;
	localparam int C_PTC_EN = 2;
	localparam int C_PHASE_EN = 3;
	localparam int C_LF_LO = 4;
	localparam logic [1:0] LF_NONE = 2'h0;
	localparam logic [1:0] LF_NO_ZC = 2'h1;
	localparam logic [1:0] LF_NO_TO = 2'h2;
	localparam logic [1:0] LF_ALL = 2'h3;

	// Reset values (levels in 0.1 A, delays in seconds or 0.1 s as noted)
	localparam logic [5:0] RST_CTRL = 6'h30;
	localparam logic [7:0] RST_GF_LVL = 8'h19;
	localparam logic [11:0] RST_GF_DLY = 12'h005;
	localparam logic [7:0] RST_GF_INH = 8'h0a;
	localparam logic [7:0] RST_GFA_LVL = 8'h14;
	localparam logic [7:0] RST_GFA_DLY = 8'h0a;

	// Latched fault bits
	localparam int F_STALL = 0;
	localparam int F_GND = 1;
	localparam int F_PTC = 2;
	localparam int F_PHASE = 3;
	localparam int F_ZC = 4;
	localparam int F_TO = 5;
	localparam int F_OVT = 6;
	localparam int F_OVL = 7;

	localparam int STARTS_MAX = 99;
	localparam logic [6:0] STARTS_LAST = 7'(STARTS_MAX - 1);

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01,
		ST_FAULT = 2'b10,
		ST_RETRY = 2'b11
	} run_state_e;

	// Whole seconds to 0.1 s ticks
	function automatic logic [11:0] tenths(input logic [7:0] s);
		tenths = {1'b0, s, 3'h0} + {3'h0, s, 1'b0};
	endfunction : tenths

endpackage : motor_prot_pkg

// [src/persist_timer.sv]
// Persistence timer: flags once a condition has held for a limit of 0.1 s ticks.
// Assumes tick is a one-cycle enable from the owner's divider.
`timescale 1ns/1ps
`default_nettype none
module persist_timer (
	input wire logic sys_clk, // System clock
	input wire logic sys_rst, // Async reset, high
	input wire logic tick, // 0.1 s enable
	input wire logic cond, // Watched condition
	input wire logic [11:0] limit, // Ticks to persist
	output logic expired // Condition held long enough
);
	typedef struct packed {
		logic [11:0] cnt;
		logic hit;
	} tmr_s;
	tmr_s q, n;

	// Count while held, restart on any gap
	always_comb begin
		n = q;
		if (!cond) begin
			n.cnt = '0;
		end else if (tick && q.cnt < limit) begin
			n.cnt = q.cnt + 12'h001;
		end
		n.hit = cond && (n.cnt >= limit);
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign expired = q.hit;

	AST_TMR_GAP: assert property (@(posedge sys_clk) disable iff (sys_rst) !cond |=> !expired)
		else $error("timer flagged after a gap");
	AST_TMR_EARLY: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$rose(expired) |-> $past(q.cnt) >= limit || limit == $past(q.cnt) + 12'h001)
		else $error("timer flagged before its limit");
endmodule : persist_timer
`default_nettype wire

// [src/motor_protection_monitor.sv]
// Protection and restart supervisor for a three-phase soft starter.
// Assumes sensing inputs are synchronous to sys_clk; software uses the plain register port.
`timescale 1ns/1ps
`default_nettype none
module motor_protection_monitor #(
	parameter int TICK_DIV = motor_prot_pkg::TICK_CYCLES // Cycles per 0.1 s tick
) (
	input wire logic sys_clk, // 25 MHz clock
	input wire logic sys_rst, // Async reset, high
	input wire logic [motor_prot_pkg::ADDR_W-1:0] reg_addr, // Register address
	input wire logic [motor_prot_pkg::DATA_W-1:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [motor_prot_pkg::DATA_W-1:0] reg_rdata, // Read data, next cycle
	input wire logic [10:0] cur_pct, // Motor current, % FLC
	input wire logic [7:0] gf_current, // Core-balance current, 0.1 A
	input wire logic ptc_hot, // Thermistor over-temperature
	input wire logic phase_abc_ok, // Line order is ABC
	input wire logic zero_cross_err, // Zero-cross problem seen
	input wire logic turn_off_err, // Switch turn-off problem seen
	input wire logic ramp_active, // Start manoeuvre in progress
	input wire logic stop_active, // Stop manoeuvre in progress
	input wire logic at_speed, // Motor at speed
	input wire logic switch_overtemp, // Power switch overtemperature
	input wire logic motor_overload, // Motor overload
	input wire logic start_cmd, // Start command level
	output logic run_enable, // Motor may run
	output logic fault_active, // Any fault latched
	output logic jam_alarm, // Jam alarm level
	output logic gf_alarm, // Ground fault alarm level
	output logic [7:0] fault_code // Latched fault bits
);
	import motor_prot_pkg::*;

	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);

	typedef struct packed {
		logic [DIV_W-1:0] div;
		logic tick;
		logic [10:0] jam_lvl;
		logic [6:0] jam_dly;
		logic [6:0] stall_dly;
		logic [5:0] ctrl;
		logic [7:0] gf_lvl;
		logic [11:0] gf_dly;
		logic [7:0] gf_inh;
		logic [7:0] gfa_lvl;
		logic [7:0] gfa_dly;
		logic [6:0] sph;
		logic [2:0] ratt;
		logic [5:0] rdly;
		run_state_e state;
		logic [7:0] fault;
		logic [2:0] att;
		logic [11:0] wait_cnt;
		logic [11:0] inh_cnt;
		logic [15:0] now;
		logic [STARTS_MAX-1:0][15:0] stamp;
		logic [6:0] wp;
		logic [6:0] rp;
		logic [6:0] cnt;
		logic [DATA_W-1:0] rdata;
	} mon_s;
	mon_s q, n;

	logic [3:0] tmr_cond;
	logic [3:0][11:0] tmr_lim;
	logic [3:0] tmr_hit;
	logic running;
	logic inhibit;
	logic starts_ok;
	logic retry_ok;
	logic launch;
	logic expire;
	logic [7:0] set;
	logic [7:0] clr;
	logic [1:0] lf_sel;

	////////////////////////////////////////////////////////////////////////////
	// Persistence conditions: jam, stall, ground trip, ground alarm
	assign running = q.state == ST_RUN;
	assign inhibit = q.inh_cnt < tenths(q.gf_inh);
	assign tmr_cond[0] = running && q.jam_lvl != '0 && cur_pct > q.jam_lvl;
	assign tmr_lim[0] = tenths({1'b0, q.jam_dly});
	assign tmr_cond[1] = running && q.stall_dly != '0 && !ramp_active && !at_speed;
	assign tmr_lim[1] = {5'h00, q.stall_dly};
	assign tmr_cond[2] = running && q.ctrl[C_GF_EN] && !inhibit && gf_current > q.gf_lvl;
	assign tmr_lim[2] = q.gf_dly;
	assign tmr_cond[3] = running && q.ctrl[C_GFA_EN] && !inhibit && gf_current > q.gfa_lvl;
	assign tmr_lim[3] = tenths(q.gfa_dly);

	// One timer per watched condition
	for (genvar i = 0; i < 4; i++) begin : g_tmr
		persist_timer u_tmr (
			.sys_clk(sys_clk),
			.sys_rst(sys_rst),
			.tick(q.tick),
			.cond(tmr_cond[i]),
			.limit(tmr_lim[i]),
			.expired(tmr_hit[i])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// Start permission and fault sources
	assign starts_ok = q.sph == '0 || q.cnt < q.sph;
	assign retry_ok = q.ratt != '0 && q.att < q.ratt && !q.fault[F_OVT] && !q.fault[F_OVL]
		&& start_cmd;
	assign expire = q.tick && q.cnt != '0 && (q.now - q.stamp[q.rp]) >= HOUR_TICKS;
	assign lf_sel = q.ctrl[C_LF_LO+1:C_LF_LO];

	// Next state, faults, start history and register file
	always_comb begin
		n = q;
		set = '0;
		clr = '0;
		launch = 1'b0;
		// Tick divider
		n.tick = q.div == DIV_LAST;
		n.div = n.tick ? '0 : q.div + 1'b1;
		if (q.tick) begin
			n.now = q.now + 16'h0001;
		end
		// Fault sources, set wins over clear
		set[F_STALL] = tmr_hit[1];
		set[F_GND] = tmr_hit[2];
		set[F_PTC] = q.ctrl[C_PTC_EN] && ptc_hot;
		set[F_ZC] = (lf_sel == LF_ALL || lf_sel == LF_NO_TO) && (ramp_active || stop_active)
			&& zero_cross_err;
		set[F_TO] = (lf_sel == LF_ALL || lf_sel == LF_NO_ZC) && (ramp_active || stop_active)
			&& turn_off_err;
		set[F_OVT] = switch_overtemp;
		set[F_OVL] = motor_overload;
		if (reg_wr && reg_addr == A_FAULT_CLR) begin
			clr = reg_wdata[7:0];
			n.att = '0;
		end
		// Run supervisor
		case (q.state)
			ST_IDLE: begin
				if (!start_cmd) begin
					n.att = '0;
				end
				if (q.fault != '0) begin
					n.state = ST_FAULT;
				end else if (start_cmd && q.ctrl[C_PHASE_EN] && !phase_abc_ok) begin
					set[F_PHASE] = 1'b1;
				end else if (start_cmd && starts_ok) begin
					n.state = ST_RUN;
					launch = 1'b1;
				end
			end
			ST_RUN: begin
				if (q.fault != '0) begin
					n.state = ST_FAULT;
				end else if (!start_cmd) begin
					n.state = ST_IDLE;
				end
			end
			ST_FAULT: begin
				if (q.fault == '0) begin
					n.state = ST_IDLE;
				end else if (retry_ok) begin
					n.state = ST_RETRY;
					n.wait_cnt = '0;
				end
			end
			ST_RETRY: begin
				if (!start_cmd || q.fault[F_OVT] || q.fault[F_OVL]) begin
					n.state = ST_FAULT;
				end else if (q.tick) begin
					if (q.wait_cnt >= tenths({2'h0, q.rdly})) begin
						clr = '1;
						n.att = q.att + 3'h1;
						n.state = ST_IDLE;
					end else begin
						n.wait_cnt = q.wait_cnt + 12'h001;
					end
				end
			end
			default: begin
				n.state = ST_IDLE;
			end
		endcase
		n.fault = (q.fault & ~clr) | set;
		// Ground inhibit window from start
		if (launch) begin
			n.inh_cnt = '0;
		end else if (q.tick && running && inhibit) begin
			n.inh_cnt = q.inh_cnt + 12'h001;
		end
		// Sliding-hour start history
		if (launch) begin
			n.stamp[q.wp] = q.now;
			n.wp = q.wp == STARTS_LAST ? '0 : q.wp + 7'h01;
		end
		if (expire) begin
			n.rp = q.rp == STARTS_LAST ? '0 : q.rp + 7'h01;
		end
		n.cnt = q.cnt + {6'h00, launch} - {6'h00, expire};
		// Register writes
		if (reg_wr) begin
			case (reg_addr)
				A_JAM_LVL: n.jam_lvl = reg_wdata[10:0];
				A_JAM_DLY: n.jam_dly = reg_wdata[6:0];
				A_STALL_DLY: n.stall_dly = reg_wdata[6:0];
				A_CTRL: n.ctrl = reg_wdata[5:0];
				A_GF_LVL: n.gf_lvl = reg_wdata[7:0];
				A_GF_DLY: n.gf_dly = reg_wdata[11:0];
				A_GF_INH: n.gf_inh = reg_wdata[7:0];
				A_GFA_LVL: n.gfa_lvl = reg_wdata[7:0];
				A_GFA_DLY: n.gfa_dly = reg_wdata[7:0];
				A_STARTS_PH: n.sph = reg_wdata[6:0];
				A_RST_ATT: n.ratt = reg_wdata[2:0];
				A_RST_DLY: n.rdly = reg_wdata[5:0];
				default: n.rdly = q.rdly;
			endcase
		end
		// Register reads, unmapped reads zero
		n.rdata = '0;
		if (reg_rd) begin
			case (reg_addr)
				A_JAM_LVL: n.rdata = DATA_W'(q.jam_lvl);
				A_JAM_DLY: n.rdata = DATA_W'(q.jam_dly);
				A_STALL_DLY: n.rdata = DATA_W'(q.stall_dly);
				A_CTRL: n.rdata = DATA_W'(q.ctrl);
				A_GF_LVL: n.rdata = DATA_W'(q.gf_lvl);
				A_GF_DLY: n.rdata = DATA_W'(q.gf_dly);
				A_GF_INH: n.rdata = DATA_W'(q.gf_inh);
				A_GFA_LVL: n.rdata = DATA_W'(q.gfa_lvl);
				A_GFA_DLY: n.rdata = DATA_W'(q.gfa_dly);
				A_STARTS_PH: n.rdata = DATA_W'(q.sph);
				A_RST_ATT: n.rdata = DATA_W'(q.ratt);
				A_RST_DLY: n.rdata = DATA_W'(q.rdly);
				A_STATUS: n.rdata = {1'b0, q.att, q.state, tmr_hit[3], tmr_hit[0], q.fault};
				A_START_CNT: n.rdata = DATA_W'(q.cnt);
				default: n.rdata = '0;
			endcase
		end
	end

	// State register with documented defaults
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			q <= '0;
			q.ctrl <= RST_CTRL;
			q.gf_lvl <= RST_GF_LVL;
			q.gf_dly <= RST_GF_DLY;
			q.gf_inh <= RST_GF_INH;
			q.gfa_lvl <= RST_GFA_LVL;
			q.gfa_dly <= RST_GFA_DLY;
			q.state <= ST_IDLE;
		end else begin
			q <= n;
		end
	end

	// Outputs
	assign reg_rdata = q.rdata;
	assign run_enable = running;
	assign fault_active = q.fault != '0;
	assign fault_code = q.fault;
	assign jam_alarm = tmr_hit[0];
	assign gf_alarm = tmr_hit[3];

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	AST_JAM_OFF: assert property ((q.jam_lvl == '0) [*2] |-> !jam_alarm)
		else $error("jam alarm with level zero");
	AST_STALL_OFF: assert property ((q.stall_dly == '0) [*3] |-> !$rose(q.fault[F_STALL]))
		else $error("stall fault with stall off");
	AST_GF_OFF: assert property (!q.ctrl[C_GF_EN] [*3] |-> !$rose(q.fault[F_GND]))
		else $error("ground trip while disabled");
	AST_GF_INH: assert property ((running && inhibit) [*3] |-> !$rose(q.fault[F_GND]))
		else $error("ground trip inside inhibit window");
	AST_PTC: assert property ($rose(q.fault[F_PTC]) |-> $past(q.ctrl[C_PTC_EN] && ptc_hot))
		else $error("thermistor fault without cause");
	AST_PHASE: assert property (q.state == ST_IDLE && q.ctrl[C_PHASE_EN] && !phase_abc_ok
		|=> q.state != ST_RUN)
		else $error("started on wrong phase order");
	AST_SPH: assert property (launch |-> starts_ok ##1 q.cnt == $past(q.cnt) + 7'h01 - {6'h00, $past(expire)})
		else $error("start beyond hourly limit");
	AST_ATT: assert property (q.state == ST_RETRY |-> q.att < q.ratt)
		else $error("retry beyond attempt count");
	AST_NO_RETRY: assert property (q.state == ST_FAULT && (q.fault[F_OVT] || q.fault[F_OVL])
		|=> q.state != ST_RETRY)
		else $error("restart after overtemp or overload");
	AST_LF_RUN: assert property ($rose(q.fault[F_ZC]) || $rose(q.fault[F_TO])
		|-> $past(ramp_active || stop_active))
		else $error("line fault during steady run");
	AST_FAULT_STOP: assert property (q.fault != '0 |=> !run_enable)
		else $error("motor running with a fault");

	COV_START: cover property (launch);
	COV_RETRY: cover property (q.state == ST_RETRY ##[1:1000] q.state == ST_IDLE);
	COV_JAM: cover property ($rose(jam_alarm));
endmodule : motor_protection_monitor
`default_nettype wire

// [sim/motor_model.sv]
// Motor model: start ramp, speed and stop manoeuvre seen by the monitor.
// Assumes run_enable from the monitor; stall_mode keeps the motor off speed.
`timescale 1ns/1ps
`default_nettype none
module motor_model #(
	parameter int RAMP = 30 // Ramp length in cycles
) (
	input wire logic sys_clk, // Clock
	input wire logic sys_rst, // Async reset, high
	input wire logic run_enable, // Monitor lets motor run
	input wire logic stall_mode, // Motor never reaches speed
	input wire logic stop_req, // Bench asks for a stop manoeuvre
	output logic ramp_active, // Start manoeuvre running
	output logic stop_active, // Stop manoeuvre running
	output logic at_speed // Motor at speed
);
	logic [7:0] cnt_r;
	logic run_r;

	// Ramp starts on each new run, speed follows unless stalled
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_r <= 8'h00;
			run_r <= 1'h0;
		end else begin
			run_r <= run_enable;
			if (run_enable && !run_r)
				cnt_r <= 8'(RAMP);
			else if (cnt_r != 8'h00)
				cnt_r <= cnt_r - 8'h01;
		end
	end

	// Sensed levels
	assign ramp_active = cnt_r != 8'h00;
	assign at_speed = run_enable && run_r && cnt_r == 8'h00 && !stall_mode;
	assign stop_active = stop_req;
endmodule : motor_model
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench of the motor protection monitor.
// Assumes a 10-cycle protection tick and the motor model for ramp and speed.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_top;
	import motor_prot_pkg::*;
	logic sys_clk = 1'h0, sys_rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, rd_d = 1'h0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata;
	logic [10:0] cur_pct = 11'h000;
	logic [7:0] gf_current = 8'h00, fault_code;
	logic ptc_hot = 1'h0, phase_abc_ok = 1'h1, zero_cross_err = 1'h0, turn_off_err = 1'h0;
	logic switch_overtemp = 1'h0, motor_overload = 1'h0, start_cmd = 1'h0, stall_mode = 1'h0, stop_req = 1'h0;
	logic ramp_active, stop_active, at_speed, run_enable, fault_active, jam_alarm, gf_alarm;
	logic [31:0] notes[$];
	logic [31:0] note;
	logic [1:0] c;
	int num_errors = 0;
	int checked = 0;

	////////////////////////////////////////////////////////////////
	// Clock
	always #20 sys_clk = ~sys_clk;

	// Design and motor
	motor_protection_monitor #(.TICK_DIV(10)) u_dut (.sys_clk, .sys_rst, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .cur_pct, .gf_current, .ptc_hot, .phase_abc_ok, .zero_cross_err,
		.turn_off_err, .ramp_active, .stop_active, .at_speed, .switch_overtemp, .motor_overload,
		.start_cmd, .run_enable, .fault_active, .jam_alarm, .gf_alarm, .fault_code);
	motor_model #(.RAMP(30)) u_motor (.sys_clk, .sys_rst, .run_enable, .stall_mode, .stop_req,
		.ramp_active, .stop_active, .at_speed);

	////////////////////////////////////////////////////////////////
	// Read data checked against the oldest note
	always @(posedge sys_clk) begin
		if (rd_d) begin
			note = notes.pop_front();
			`CHK("rdata", note[15:0] & note[31:16], reg_rdata & note[31:16])
		end
		rd_d <= reg_rd;
	end

	// Bus and helper tasks
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'h0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
		@(posedge sys_clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		notes.push_back({m, e});
		@(posedge sys_clk);
		reg_rd <= 1'h0;
	endtask : rd

	function automatic logic [15:0] st(input logic [2:0] a, input run_state_e s, input logic [7:0] f);
		return {1'h0, a, s, 2'h0, f};
	endfunction : st

	task automatic go;
		start_cmd <= 1'h1;
		cyc(40);
	endtask : go

	task automatic clr;
		start_cmd <= 1'h0;
		cyc(3);
		wr(A_FAULT_CLR, 16'h00ff);
		cyc(3);
	endtask : clr

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim

	////////////////////////////////////////////////////////////////
	// Watchdog
	initial begin
		cyc(20000);
		num_errors++;
		end_sim;
	end

	// Tests
	initial begin
		logic [3:0] ad[10] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hf};
		logic [15:0] dv[10] = '{16'h30, 16'h19, 16'h5, 16'ha, 16'h14, 16'ha, 16'h0, 16'h0, 16'h0, 16'h0};
		void'($urandom(6255));
		cyc(20);
		sys_rst <= 1'h0;
		wr(4'hf, 16'hffff);
		for (int i = 0; i < 10; i++)
			rd(ad[i], dv[i], 16'hffff);
		$display("test defaults done");
		wr(A_STARTS_PH, 16'h0002);
		for (int i = 0; i < 3; i++) begin
			go;
			rd(A_STATUS, st(0, i < 2 ? ST_RUN : ST_IDLE, 8'h00), 16'h0cff);
			clr;
		end
		rd(A_START_CNT, 16'h0002, 16'hffff);
		wr(A_STARTS_PH, 16'h0000);
		$display("test starts done");
		wr(A_JAM_LVL, 16'd100);
		wr(A_JAM_DLY, 16'h0001);
		go;
		cur_pct <= 11'(101 + $urandom % 400);
		cyc(60);
		cur_pct <= 11'd100;
		cyc(3);
		cur_pct <= 11'(101 + $urandom % 400);
		cyc(80);
		rd(A_STATUS, st(0, ST_RUN, 8'h00), 16'h0dff);
		cyc(40);
		rd(A_STATUS, st(0, ST_RUN, 8'h00) | 16'h0100, 16'h0dff);
		`CHK("jam_alarm", 1'h1, jam_alarm)
		cur_pct <= 11'h000;
		cyc(3);
		rd(A_STATUS, st(0, ST_RUN, 8'h00), 16'h0dff);
		$display("test jam done");
		gf_current <= 8'd26;
		cyc(80);
		rd(A_STATUS, st(0, ST_RUN, 8'h00), 16'h0eff);
		wr(A_GF_INH, 16'h0000);
		wr(A_GFA_DLY, 16'h0000);
		wr(A_CTRL, 16'h0033);
		cyc(20);
		rd(A_STATUS, st(0, ST_RUN, 8'h00) | 16'h0200, 16'h0eff);
		`CHK("gf_alarm", 1'h1, gf_alarm)
		cyc(60);
		rd(A_STATUS, st(0, ST_FAULT, 8'h02), 16'h0cff);
		`CHK("run_enable", 1'h0, run_enable)
		`CHK("fault_code", 8'h02, fault_code)
		`CHK("fault_active", 1'h1, fault_active)
		gf_current <= 8'h00;
		clr;
		`CHK("fault_active", 1'h0, fault_active)
		$display("test ground done");
		go;
		ptc_hot <= 1'h1;
		cyc(5);
		rd(A_STATUS, st(0, ST_RUN, 8'h00), 16'h0cff);
		wr(A_CTRL, 16'h0034);
		cyc(3);
		rd(A_STATUS, st(0, ST_FAULT, 8'h04), 16'h0cff);
		ptc_hot <= 1'h0;
		clr;
		wr(A_CTRL, 16'h0038);
		phase_abc_ok <= 1'h0;
		start_cmd <= 1'h1;
		cyc(5);
		rd(A_STATUS, st(0, ST_FAULT, 8'h08), 16'h0cff);
		`CHK("run_enable", 1'h0, run_enable)
		phase_abc_ok <= 1'h1;
		clr;
		$display("test thermistor phase done");
		for (int i = 0; i < 4; i++) begin
			c = 2'(i);
			wr(A_CTRL, {10'h000, c, 4'h0});
			go;
			zero_cross_err <= 1'h1;
			turn_off_err <= 1'h1;
			cyc(5);
			rd(A_STATUS, st(0, ST_RUN, 8'h00), 16'h0cff);
			stop_req <= 1'h1;
			cyc(3);
			rd(A_STATUS, {8'h00, 2'h0, c[0], c[1], 4'h0}, 16'h00ff);
			zero_cross_err <= 1'h0;
			turn_off_err <= 1'h0;
			stop_req <= 1'h0;
			clr;
		end
		$display("test line faults done");
		wr(A_CTRL, 16'h0030);
		wr(A_STALL_DLY, 16'h0005);
		stall_mode <= 1'h1;
		start_cmd <= 1'h1;
		cyc(50);
		rd(A_STATUS, st(0, ST_RUN, 8'h00), 16'h0cff);
		cyc(60);
		rd(A_STATUS, st(0, ST_FAULT, 8'h01), 16'h0cff);
		stall_mode <= 1'h0;
		wr(A_STALL_DLY, 16'h0000);
		clr;
		$display("test stall done");
		wr(A_RST_ATT, 16'h0002);
		wr(A_RST_DLY, 16'h0001);
		wr(A_CTRL, 16'h0034);
		go;
		// Start command stays high through the retries
		for (int k = 0; k < 3; k++) begin
			ptc_hot <= 1'h1;
			cyc(2);
			ptc_hot <= 1'h0;
			cyc(5);
			rd(A_STATUS, st(3'(k), k < 2 ? ST_RETRY : ST_FAULT, 8'h04), 16'h7cff);
			cyc(120);
			rd(A_STATUS, k < 2 ? st(3'(k + 1), ST_RUN, 8'h00) : st(3'h2, ST_FAULT, 8'h04), 16'h7cff);
		end
		clr;
		for (int i = 0; i < 2; i++) begin
			go;
			{switch_overtemp, motor_overload} <= i ? 2'h2 : 2'h1;
			cyc(2);
			{switch_overtemp, motor_overload} <= 2'h0;
			cyc(130);
			rd(A_STATUS, st(0, ST_FAULT, i ? 8'h40 : 8'h80), 16'h7cff);
			clr;
		end
		$display("test restart done");
		cyc(5);
		end_sim;
	end
endmodule : tb_top
`default_nettype wire
